// ---- logic/cfs_cycle_issuer.sv ----
`timescale 1ns/1ps
module cfs_cycle_issuer
  import cfs_pkg::*;
(
  input  wire logic   i_ref_clk,
  input  wire logic   i_reset,
  cfs_bus_if.issuer   bus,
  input  wire logic   i_cycle_ack,
  input  wire logic   i_snoop_hit_modified_n_active,
  input  wire logic   i_address_hold_request,
  input  wire logic   i_bus_free,
  output logic        o_address_strobe_n,
  output cfs_cyc_t    o_cycle_kind,
  output logic [LINE_ADDR_W-1:0] o_cycle_addr,
  output logic        o_busy
);
  logic [1:0] gap_cnt;
  logic       start;

  // Counts clocks since the hit-modified output went active.
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      gap_cnt <= 2'd0;
    end else if (!i_snoop_hit_modified_n_active) begin
      gap_cnt <= 2'd0;
    end else if (gap_cnt != 2'(WB_ADS_GAP_CLKS)) begin
      gap_cnt <= gap_cnt + 2'd1;
    end
  end

  assign bus.gap_ok = !i_snoop_hit_modified_n_active || (gap_cnt == 2'(WB_ADS_GAP_CLKS));
  // Only a snoop writeback may start under address hold.
  assign start = bus.req && !o_busy && i_bus_free && bus.gap_ok &&
                 (!i_address_hold_request || bus.kind == CFS_CYC_WRITEBACK);
  assign bus.done = o_busy && i_cycle_ack;

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_busy             <= 1'b0;
      o_address_strobe_n <= 1'b1;
      o_cycle_kind       <= CFS_CYC_NONE;
      o_cycle_addr       <= '0;
    end else begin
      o_address_strobe_n <= !start;
      if (start) begin
        o_busy       <= 1'b1;
        o_cycle_kind <= bus.kind;
        o_cycle_addr <= bus.addr;
      end else if (bus.done) begin
        o_busy       <= 1'b0;
        o_cycle_kind <= CFS_CYC_NONE;
      end
    end
  end
endmodule

// ---- logic/cfs_flush_snoop.sv ----
`timescale 1ns/1ps
module cfs_flush_snoop
  import cfs_pkg::*;
#(
  parameter int SETS = cfs_pkg::CACHE_SETS
) (
  input  wire logic                            i_ref_clk,
  input  wire logic                            i_reset,
  input  wire logic                            i_flush_request_n,
  input  wire logic                            i_processor_role_strap,
  input  wire logic                            i_dual_mode,
  input  wire logic                            i_instr_boundary,
  input  wire logic                            i_halted,
  input  wire logic                            i_peer_flush_done,
  input  wire logic                            i_external_snoop_strobe_n,
  input  wire logic [cfs_pkg::LINE_ADDR_W-1:0] i_snoop_addr,
  input  wire logic                            i_snoop_invalidate,
  input  wire logic                            i_address_hold_request,
  input  wire logic                            i_bus_backoff_n,
  input  wire logic                            i_bus_free,
  input  wire logic                            i_cycle_ack,
  input  wire logic                            i_fill_valid,
  input  wire logic                            i_fill_dcache,
  input  wire logic                            i_fill_modified,
  input  wire logic [cfs_pkg::LINE_ADDR_W-1:0] i_fill_addr,
  input  wire logic                            i_peer_hit_n,
  input  wire logic                            i_peer_hit_modified_n,
  output logic                                 o_hit_n,
  output logic                                 o_hit_oe_n,
  output logic                                 o_snoop_hit_modified_n,
  output logic                                 o_snoop_hit_modified_oe_n,
  output logic                                 o_address_strobe_n,
  output cfs_pkg::cfs_cyc_t                    o_cycle_kind,
  output logic [cfs_pkg::LINE_ADDR_W-1:0]      o_cycle_addr,
  output logic                                 o_interrupt_block,
  output logic                                 o_flush_active,
  output logic                                 o_halt_resume,
  output logic                                 o_peer_flush_done,
  output logic                                 o_tristate_test
);
  import cfs_pkg::*;

  if (SETS != (1 << SET_IDX_W)) begin : g_bad_sets
    $error("SETS must equal 2**SET_IDX_W");
  end

  // ****************************************************************
  // Flush request sampling
  // ****************************************************************
  typedef enum logic [2:0] {
    CFS_F_IDLE    = 3'b000,
    CFS_F_PENDING = 3'b001,
    CFS_F_PEER    = 3'b010,
    CFS_F_SCAN    = 3'b011,
    CFS_F_WB_WAIT = 3'b100,
    CFS_F_ACK     = 3'b101,
    CFS_F_ACK_END = 3'b110
  } cfs_fstate_t;

  cfs_fstate_t            fstate;
  logic                   flush_sync;
  logic                   flush_prev;
  logic                   flush_level;
  logic                   flush_fall;
  logic                   reset_prev;
  logic                   halted_saved;
  logic                   is_primary;
  logic [SET_IDX_W-1:0]   scan_idx;

  cfs_sync #(.WIDTH(1)) u_flush_sync (
    .i_ref_clk   (i_ref_clk),
    .i_reset     (1'b0),
    .i_async     (i_flush_request_n),
    .i_reset_val (1'b1),
    .o_sync      (flush_sync)
  );

  // Dual mode takes the pin directly so both processors see the same clock.
  assign flush_level = i_dual_mode ? i_flush_request_n : flush_sync;
  assign flush_fall  = flush_prev && !flush_level;
  assign is_primary  = !i_processor_role_strap;

  always_ff @(posedge i_ref_clk) begin
    flush_prev <= flush_level;
    reset_prev <= i_reset;
  end

  // The strap level is caught by a clocked process at reset release.
  always_ff @(posedge i_ref_clk) begin
    if (reset_prev && !i_reset) begin
      o_tristate_test <= !flush_level;
    end else if (i_reset && !reset_prev) begin
      o_tristate_test <= 1'b0;
    end
  end

  // ****************************************************************
  // Cache line state
  // ****************************************************************
  cfs_line_t              dstate [SETS];
  cfs_line_t              istate [SETS];
  logic [LINE_ADDR_W-1:0] dtag   [SETS];
  logic [LINE_ADDR_W-1:0] itag   [SETS];

  function automatic logic [SET_IDX_W-1:0] set_of(input logic [LINE_ADDR_W-1:0] a);
    return a[SET_IDX_W-1:0];
  endfunction

  // ****************************************************************
  // Snoop pipeline
  // ****************************************************************
  logic                   snoop_seen;
  logic                   snoop_recent;
  logic                   snoop_take;
  logic                   snoop_s1;
  logic                   snoop_inv_s1;
  logic [LINE_ADDR_W-1:0] snoop_addr_s1;
  logic                   hit_d;
  logic                   hit_i;
  logic                   hit_m;
  logic                   snoop_hit_modified_n_active;
  logic                   snoop_wb_pend;
  logic [LINE_ADDR_W-1:0] snoop_wb_addr;
  logic                   snoop_wb_inv;
  logic [1:0]             snoop_hit_modified_n_tail;
  logic                   wb_done_snoop;
  logic                   own_addr_bus;
  logic                   flush_wb_req;

  cfs_bus_if bus ();

  assign own_addr_bus = !o_address_strobe_n || (bus.req && !i_address_hold_request &&
                                               i_bus_backoff_n && i_bus_free);
  assign snoop_seen = !i_external_snoop_strobe_n;
  // Ignored while driving the address bus, during snoop_hit_modified_n, or just after a strobe.
  assign snoop_take = snoop_seen && !own_addr_bus && !snoop_hit_modified_n_active &&
                      !snoop_recent;

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      snoop_recent  <= 1'b0;
      snoop_s1      <= 1'b0;
      snoop_inv_s1  <= 1'b0;
      snoop_addr_s1 <= '0;
    end else begin
      snoop_recent  <= snoop_seen || !o_address_strobe_n;
      snoop_s1      <= snoop_take;
      snoop_inv_s1  <= i_snoop_invalidate;
      snoop_addr_s1 <= i_snoop_addr;
    end
  end

  always_comb begin
    hit_d = dstate[set_of(snoop_addr_s1)] != CFS_LINE_INVALID &&
            dtag[set_of(snoop_addr_s1)] == snoop_addr_s1;
    hit_i = istate[set_of(snoop_addr_s1)] != CFS_LINE_INVALID &&
            itag[set_of(snoop_addr_s1)] == snoop_addr_s1;
    hit_m = hit_d && dstate[set_of(snoop_addr_s1)] == CFS_LINE_MODIFIED;
  end

  // Results appear two clocks after the strobe is taken; hit holds between snoops, hit-modified goes high after its writeback.
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_hit_n                <= HIT_N_RESET;
      o_snoop_hit_modified_n <= SNOOP_HIT_MODIFIED_N_N_RESET;
      snoop_hit_modified_n_active            <= 1'b0;
      snoop_wb_pend          <= 1'b0;
      snoop_wb_addr          <= '0;
      snoop_wb_inv           <= 1'b0;
      snoop_hit_modified_n_tail              <= 2'd0;
    end else begin
      if (snoop_s1) begin
        o_hit_n <= !(hit_d || hit_i);
        // Hit-modified implies a data hit, so hit is low with it.
        o_snoop_hit_modified_n <= !hit_m;
        snoop_hit_modified_n_active            <= hit_m;
        snoop_wb_pend          <= hit_m;
        snoop_wb_addr          <= snoop_addr_s1;
        snoop_wb_inv           <= snoop_inv_s1;
      end else if (snoop_hit_modified_n_tail == 2'd1) begin
        o_snoop_hit_modified_n <= 1'b1;
        snoop_hit_modified_n_active            <= 1'b0;
      end
      if (wb_done_snoop) begin
        snoop_wb_pend <= 1'b0;
        snoop_hit_modified_n_tail     <= 2'(SNOOP_HIT_MODIFIED_N_HOLD_CLKS);
      end else if (snoop_hit_modified_n_tail != 2'd0) begin
        snoop_hit_modified_n_tail <= snoop_hit_modified_n_tail - 2'd1;
      end
    end
  end

  // Pins are always driven; the peer hit inputs are not sampled, in dual mode either.
  assign o_hit_oe_n                = 1'b0;
  assign o_snoop_hit_modified_oe_n = 1'b0;

  // ****************************************************************
  // Flush sequencer
  // ****************************************************************
  assign flush_wb_req = fstate == CFS_F_SCAN && dstate[scan_idx] == CFS_LINE_MODIFIED;

  always_comb begin
    bus.req  = 1'b0;
    bus.kind = CFS_CYC_NONE;
    bus.addr = '0;
    if (snoop_wb_pend) begin
      bus.req  = 1'b1;
      bus.kind = CFS_CYC_WRITEBACK;
      bus.addr = snoop_wb_addr;
    end else if (flush_wb_req && !i_address_hold_request && i_bus_backoff_n) begin
      bus.req  = 1'b1;
      bus.kind = CFS_CYC_WRITEBACK;
      bus.addr = dtag[scan_idx];
    end else if (fstate == CFS_F_ACK) begin
      bus.req  = 1'b1;
      bus.kind = CFS_CYC_FLUSH_ACK;
    end
  end

  logic issuer_busy;
  logic busy_wb_snoop;

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      busy_wb_snoop <= 1'b0;
    end else if (!o_address_strobe_n) begin
      busy_wb_snoop <= snoop_wb_pend;
    end
  end

  assign wb_done_snoop = bus.done && busy_wb_snoop && o_cycle_kind == CFS_CYC_WRITEBACK;

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      fstate       <= CFS_F_IDLE;
      scan_idx     <= '0;
      halted_saved <= 1'b0;
    end else begin
      case (fstate)
        CFS_F_IDLE: begin
          if (flush_fall) begin
            fstate       <= CFS_F_PENDING;
            halted_saved <= i_halted;
          end
        end
        CFS_F_PENDING: begin
          if (i_instr_boundary || i_halted) begin
            fstate   <= (i_dual_mode && is_primary) ? CFS_F_PEER : CFS_F_SCAN;
            scan_idx <= '0;
          end
        end
        CFS_F_PEER: begin
          if (i_peer_flush_done) begin
            fstate <= CFS_F_SCAN;
          end
        end
        CFS_F_SCAN: begin
          if (!flush_wb_req || (bus.done && !busy_wb_snoop)) begin
            if (scan_idx == SET_IDX_W'(SETS - 1)) begin
              fstate <= CFS_F_WB_WAIT;
            end else begin
              scan_idx <= scan_idx + 1'b1;
            end
          end
        end
        CFS_F_WB_WAIT: begin
          if (!issuer_busy) begin
            fstate <= (i_dual_mode && !is_primary) ? CFS_F_ACK_END : CFS_F_ACK;
          end
        end
        CFS_F_ACK: begin
          if (bus.done && o_cycle_kind == CFS_CYC_FLUSH_ACK) begin
            fstate <= CFS_F_ACK_END;
          end
        end
        CFS_F_ACK_END: fstate <= CFS_F_IDLE;
        default: fstate <= CFS_F_IDLE;
      endcase
    end
  end

  assign o_flush_active    = fstate != CFS_F_IDLE;
  assign o_interrupt_block = fstate != CFS_F_IDLE && fstate != CFS_F_PENDING;
  assign o_halt_resume     = fstate == CFS_F_ACK_END && halted_saved;
  assign o_peer_flush_done = fstate == CFS_F_ACK_END && i_dual_mode && !is_primary;

  // ****************************************************************
  // Cache state updates
  // ****************************************************************
  for (genvar s = 0; s < SETS; s++) begin : g_set
    always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
        dstate[s] <= CFS_LINE_INVALID;
        istate[s] <= CFS_LINE_INVALID;
        dtag[s]   <= '0;
        itag[s]   <= '0;
      end else if (fstate == CFS_F_WB_WAIT && !issuer_busy) begin
        dstate[s] <= CFS_LINE_INVALID;
        istate[s] <= CFS_LINE_INVALID;
      end else begin
        if (fstate == CFS_F_SCAN && scan_idx == SET_IDX_W'(s) && bus.done &&
            !busy_wb_snoop) begin
          dstate[s] <= CFS_LINE_EXCLUSIVE;
        end
        if (snoop_s1 && set_of(snoop_addr_s1) == SET_IDX_W'(s)) begin
          if (hit_d && !hit_m) dstate[s] <= snoop_inv_s1 ? CFS_LINE_INVALID : CFS_LINE_SHARED;
          if (hit_i) istate[s] <= snoop_inv_s1 ? CFS_LINE_INVALID : CFS_LINE_SHARED;
        end
        if (wb_done_snoop && set_of(snoop_wb_addr) == SET_IDX_W'(s)) begin
          dstate[s] <= snoop_wb_inv ? CFS_LINE_INVALID : CFS_LINE_SHARED;
        end
        if (i_fill_valid && set_of(i_fill_addr) == SET_IDX_W'(s)) begin
          if (i_fill_dcache) begin
            dstate[s] <= i_fill_modified ? CFS_LINE_MODIFIED : CFS_LINE_EXCLUSIVE;
            dtag[s]   <= i_fill_addr;
          end else begin
            istate[s] <= CFS_LINE_SHARED;
            itag[s]   <= i_fill_addr;
          end
        end
      end
    end
  end

  cfs_cycle_issuer u_issuer (
    .i_ref_clk              (i_ref_clk),
    .i_reset                (i_reset),
    .bus                    (bus),
    .i_cycle_ack            (i_cycle_ack),
    .i_snoop_hit_modified_n_active          (snoop_hit_modified_n_active && snoop_wb_pend),
    .i_address_hold_request (i_address_hold_request || !i_bus_backoff_n),
    .i_bus_free             (i_bus_free),
    .o_address_strobe_n     (o_address_strobe_n),
    .o_cycle_kind           (o_cycle_kind),
    .o_cycle_addr           (o_cycle_addr),
    .o_busy                 (issuer_busy)
  );

endmodule

// ---- logic/cfs_sync.sv ----
`timescale 1ns/1ps
module cfs_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             i_ref_clk,
  input  wire logic             i_reset,
  input  wire logic [WIDTH-1:0] i_async,
  input  wire logic [WIDTH-1:0] i_reset_val,
  output logic      [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] stage1;

  // The first stage feeds only the second stage.
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      stage1 <= i_reset_val;
      o_sync <= i_reset_val;
    end else begin
      stage1 <= i_async;
      o_sync <= stage1;
    end
  end
endmodule

// ---- shared/cfs_bus_if.sv ----
`timescale 1ns/1ps
// Bus cycle request between the flush/snoop controller and the cycle issuer.
interface cfs_bus_if;
  import cfs_pkg::*;
  logic                   req;
  cfs_cyc_t               kind;
  logic [LINE_ADDR_W-1:0] addr;
  logic                   gap_ok;
  logic                   done;
  modport ctrl (output req, output kind, output addr, input gap_ok, input done);
  modport issuer (input req, input kind, input addr, output gap_ok, output done);
endinterface

// ---- shared/cfs_pkg.sv ----
package cfs_pkg;

  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS      = 100;
  localparam int SNOOP_RESULT_CLKS  = 2;
  localparam int WB_ADS_GAP_CLKS    = 2;
  localparam int SNOOP_HIT_MODIFIED_N_HOLD_CLKS     = 2;

  // ****************************************************************
  // Widths and reset values
  // ****************************************************************
  localparam int LINE_ADDR_W        = 27;
  localparam int CACHE_SETS         = 16;
  localparam int SET_IDX_W          = 4;
  localparam logic HIT_N_RESET      = 1'b1;
  localparam logic SNOOP_HIT_MODIFIED_N_N_RESET     = 1'b1;

  // Line states kept per set in the model of each cache.
  typedef enum logic [1:0] {
    CFS_LINE_INVALID   = 2'b00,
    CFS_LINE_SHARED    = 2'b01,
    CFS_LINE_EXCLUSIVE = 2'b10,
    CFS_LINE_MODIFIED  = 2'b11
  } cfs_line_t;

  // Bus cycle kinds the block asks the bus unit to run.
  typedef enum logic [1:0] {
    CFS_CYC_NONE      = 2'b00,
    CFS_CYC_WRITEBACK = 2'b01,
    CFS_CYC_FLUSH_ACK = 2'b10
  } cfs_cyc_t;

endpackage

// ---- test/cfs_bus_partner.sv ----
`timescale 1ns/1ps
module cfs_bus_partner (
  input  wire logic                            i_ref_clk,
  input  wire logic                            i_reset,
  input  wire logic                            i_address_strobe_n,
  input  wire logic                            i_slow,
  input  wire cfs_pkg::cfs_cyc_t               i_cycle_kind,
  input  wire logic [cfs_pkg::LINE_ADDR_W-1:0] i_cycle_addr,
  output logic                                 o_cycle_ack,
  output logic                                 o_bus_free,
  output logic [7:0]                           o_wb_count,
  output logic [7:0]                           o_fa_count,
  output logic [cfs_pkg::LINE_ADDR_W-1:0]      o_last_addr
);
  import cfs_pkg::*;
  // ****************************************************************
  // Bus completion
  // ****************************************************************
  // The bus stays busy until the cycle ends, so no other access can touch the line.
  logic       busy;
  logic [3:0] wait_cnt;
  assign o_bus_free = ~busy;
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      busy <= 1'b0;
      wait_cnt <= 4'h0;
      o_cycle_ack <= 1'b0;
    end else if (!i_address_strobe_n) begin
      busy <= 1'b1;
      wait_cnt <= i_slow ? 4'h6 : 4'h1;
      o_cycle_ack <= 1'b0;
    end else if (busy && wait_cnt == 4'h0) begin
      busy <= 1'b0;
      o_cycle_ack <= 1'b1;
    end else begin
      wait_cnt <= wait_cnt - 4'h1;
      o_cycle_ack <= 1'b0;
    end
  end
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_wb_count <= 8'h00;
      o_fa_count <= 8'h00;
      o_last_addr <= '0;
    end else if (!i_address_strobe_n && i_cycle_kind == CFS_CYC_WRITEBACK) begin
      o_wb_count <= o_wb_count + 8'h01;
      o_last_addr <= i_cycle_addr;
    end else if (!i_address_strobe_n && i_cycle_kind == CFS_CYC_FLUSH_ACK) begin
      o_fa_count <= o_fa_count + 8'h01;
    end
  end
endmodule

// ---- test/cfs_chk.sv ----
`timescale 1ns/1ps
module cfs_chk #(
  parameter int SETS = cfs_pkg::CACHE_SETS
) (
  input wire logic              i_ref_clk,
  input wire logic              i_reset,
  input wire logic              i_external_snoop_strobe_n,
  input wire logic              i_address_hold_request,
  input wire logic              i_instr_boundary,
  input wire logic              i_halted,
  input wire logic              o_hit_n,
  input wire logic              o_hit_oe_n,
  input wire logic              o_snoop_hit_modified_n,
  input wire logic              o_snoop_hit_modified_oe_n,
  input wire logic              o_address_strobe_n,
  input wire cfs_pkg::cfs_cyc_t o_cycle_kind,
  input wire logic              o_flush_active,
  input wire logic              o_interrupt_block
);
  import cfs_pkg::*;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);
  sequence wb_start;
    !o_address_strobe_n && o_cycle_kind == CFS_CYC_WRITEBACK;
  endsequence
  sequence bus_quiet2;
    o_address_strobe_n ##1 o_address_strobe_n;
  endsequence
  chk_hit_by_snoop: assert property (
    $changed(o_hit_n) |-> $past(i_external_snoop_strobe_n, 2) == 1'b0)
    else $error("hit changed without a snoop two clocks before");
  chk_mod_needs_hit: assert property (!o_snoop_hit_modified_n |-> !o_hit_n)
    else $error("modified hit shown without hit");
  chk_pins_driven: assert property (
    o_hit_oe_n == 1'b0 && o_snoop_hit_modified_oe_n == 1'b0)
    else $error("hit pins not driven");
  chk_wb_strobe_gap: assert property ($fell(o_snoop_hit_modified_n) |-> bus_quiet2)
    else $error("writeback strobe too soon after modified hit");
  chk_mod_wb_sched: assert property ($fell(o_snoop_hit_modified_n) |-> ##[2:40] wb_start)
    else $error("no writeback after modified hit");
  chk_hold_only_wb: assert property (
    !o_address_strobe_n && i_address_hold_request |-> o_cycle_kind == CFS_CYC_WRITEBACK)
    else $error("non writeback cycle under address hold");
  chk_snoop_ignored: assert property (
    !o_snoop_hit_modified_n && !i_external_snoop_strobe_n |-> ##2 $stable(o_hit_n))
    else $error("snoop taken while modified hit active");
  chk_flush_irq_mask: assert property (
    o_flush_active && (i_instr_boundary || i_halted) |=> o_interrupt_block || !o_flush_active)
    else $error("interrupts not blocked during flush");
endmodule

bind cfs_flush_snoop cfs_chk #(.SETS(SETS)) cfs_chk_inst (
  .i_ref_clk(i_ref_clk), .i_reset(i_reset),
  .i_external_snoop_strobe_n(i_external_snoop_strobe_n),
  .i_address_hold_request(i_address_hold_request), .o_hit_n(o_hit_n),
  .i_instr_boundary(i_instr_boundary), .i_halted(i_halted),
  .o_hit_oe_n(o_hit_oe_n), .o_snoop_hit_modified_n(o_snoop_hit_modified_n),
  .o_snoop_hit_modified_oe_n(o_snoop_hit_modified_oe_n),
  .o_address_strobe_n(o_address_strobe_n), .o_cycle_kind(o_cycle_kind),
  .o_flush_active(o_flush_active), .o_interrupt_block(o_interrupt_block)
);

// ---- test/tb.sv ----
`timescale 1ns/1ps
module tb;
  import cfs_pkg::*;
  // ****************************************************************
  // Stimulus and scenarios
  // ****************************************************************
  logic i_ref_clk, i_reset = 1'b1, flush_n = 1'b1, role = 1'b0, dual = 1'b0, halted = 1'b0;
  logic boundary = 1'b1, snoop_n = 1'b1, inval = 1'b0, hold = 1'b0, slow = 1'b0;
  logic fill_v = 1'b0, fill_dc = 1'b0, fill_mod = 1'b0, peer_in = 1'b0;
  logic ack, bus_free, hit_n, mod_n, strobe_n, flush_act, resume, peer_done, tristate;
  logic [LINE_ADDR_W-1:0] snoop_addr = '0, fill_addr = '0, cyc_addr, wb_addr;
  logic [7:0] wb_cnt, fa_cnt, n0, n1;
  cfs_cyc_t kind;
  int errors = 0, checks = 0, resume_seen = 0, peer_seen = 0;

  cfs_flush_snoop cfs_flush_snoop_inst (
    .i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_flush_request_n(flush_n),
    .i_processor_role_strap(role), .i_dual_mode(dual), .i_instr_boundary(boundary),
    .i_halted(halted), .i_peer_flush_done(peer_in), .i_external_snoop_strobe_n(snoop_n),
    .i_snoop_addr(snoop_addr), .i_snoop_invalidate(inval), .i_address_hold_request(hold),
    .i_bus_backoff_n(1'b1), .i_bus_free(bus_free), .i_cycle_ack(ack), .i_fill_valid(fill_v),
    .i_fill_dcache(fill_dc), .i_fill_modified(fill_mod), .i_fill_addr(fill_addr),
    .i_peer_hit_n(1'b1), .i_peer_hit_modified_n(1'b1), .o_hit_n(hit_n), .o_hit_oe_n(),
    .o_snoop_hit_modified_n(mod_n), .o_snoop_hit_modified_oe_n(),
    .o_address_strobe_n(strobe_n), .o_cycle_kind(kind), .o_cycle_addr(cyc_addr),
    .o_interrupt_block(), .o_flush_active(flush_act), .o_halt_resume(resume),
    .o_peer_flush_done(peer_done), .o_tristate_test(tristate)
  );
  cfs_bus_partner cfs_bus_partner_inst (
    .i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_address_strobe_n(strobe_n), .i_slow(slow),
    .i_cycle_kind(kind), .i_cycle_addr(cyc_addr), .o_cycle_ack(ack), .o_bus_free(bus_free),
    .o_wb_count(wb_cnt), .o_fa_count(fa_cnt), .o_last_addr(wb_addr)
  );

  initial begin
    i_ref_clk = 1'b0;
    forever #(CLK_PERIOD_NS / 2) i_ref_clk = ~i_ref_clk;
  end
  always @(posedge i_ref_clk) begin
    if (resume === 1'b1) resume_seen++;
    if (peer_done === 1'b1) peer_seen++;
  end

  task automatic end_sim();
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_ref_clk);
  endtask
  task automatic fill(input logic [LINE_ADDR_W-1:0] a, input logic dc, input logic md);
    @(posedge i_ref_clk);
    fill_v <= 1'b1;
    fill_addr <= a;
    fill_dc <= dc;
    fill_mod <= md;
    @(posedge i_ref_clk);
    fill_v <= 1'b0;
  endtask
  task automatic snoop(input logic [LINE_ADDR_W-1:0] a, input logic iv, input logic eh,
                       input logic em);
    @(posedge i_ref_clk);
    snoop_n <= 1'b0;
    snoop_addr <= a;
    inval <= iv;
    @(posedge i_ref_clk);
    snoop_n <= 1'b1;
    tick(2);
    #1;
    check("hit_n", 32'(eh), 32'(hit_n));
    check("hit_mod_n", 32'(em), 32'(mod_n));
  endtask
  // A request held low for n clocks, starting at the next clock edge.
  task automatic flush_req(input int n);
    @(posedge i_ref_clk);
    flush_n <= 1'b0;
    tick(n);
    flush_n <= 1'b1;
  endtask
  task automatic wait_flush(input logic again);
    int k;
    for (k = 0; k < 40 && flush_act !== 1'b1; k++) tick(1);
    check("flush_start", 32'd1, 32'(flush_act));
    if (again) flush_req(3);
    for (k = 0; k < 900 && flush_act !== 1'b0; k++) tick(1);
    check("flush_active", 32'd0, 32'(flush_act));
    tick(4);
  endtask

  task automatic t_snoops();
    snoop(27'h000_0031, 1'b0, 1'b1, 1'b1);
    fill(27'h000_0011, 1'b0, 1'b0);
    snoop(27'h000_0031, 1'b0, 1'b1, 1'b1);
    snoop(27'h000_0011, 1'b0, 1'b0, 1'b1);
    tick(3);
    check("hit_held", 32'd0, 32'(hit_n));
    snoop(27'h000_0011, 1'b1, 1'b0, 1'b1);
    snoop(27'h000_0011, 1'b0, 1'b1, 1'b1);
  endtask
  task automatic t_mod_snoop();
    fill(27'h000_0022, 1'b1, 1'b1);
    n0 = wb_cnt;
    @(posedge i_ref_clk);
    hold <= 1'b1;
    snoop(27'h000_0022, 1'b1, 1'b0, 1'b0);
    snoop(27'h000_0031, 1'b0, 1'b0, 1'b0);
    for (int k = 0; k < 40 && wb_cnt === n0; k++) tick(1);
    check("wb_count", 32'(n0 + 8'h01), 32'(wb_cnt));
    check("wb_addr", 32'h0000_0022, 32'(wb_addr));
    @(posedge i_ref_clk);
    hold <= 1'b0;
    for (int k = 0; k < 20 && mod_n !== 1'b1; k++) tick(1);
    check("hit_mod_n", 32'd1, 32'(mod_n));
    snoop(27'h000_0022, 1'b0, 1'b1, 1'b1);
  endtask
  task automatic t_flush();
    fill(27'h000_0033, 1'b1, 1'b1);
    fill(27'h000_0055, 1'b1, 1'b1);
    fill(27'h000_0077, 1'b0, 1'b0);
    n0 = wb_cnt;
    n1 = fa_cnt;
    @(posedge i_ref_clk);
    slow <= 1'b1;
    flush_req(3);
    wait_flush(1'b1);
    check("wb_count", 32'(n0 + 8'h02), 32'(wb_cnt));
    check("ack_count", 32'(n1 + 8'h01), 32'(fa_cnt));
    snoop(27'h000_0077, 1'b0, 1'b1, 1'b1);
    slow <= 1'b0;
  endtask
  task automatic t_halt_flush();
    @(posedge i_ref_clk);
    halted <= 1'b1;
    boundary <= 1'b0;
    n1 = fa_cnt;
    resume_seen = 0;
    flush_req(2);
    wait_flush(1'b0);
    check("resume", 32'd1, 32'(resume_seen));
    check("ack_count", 32'(n1 + 8'h01), 32'(fa_cnt));
    halted <= 1'b0;
    boundary <= 1'b1;
  endtask
  task automatic t_dual_flush();
    @(posedge i_ref_clk);
    dual <= 1'b1;
    role <= 1'b1;
    tick(2);
    n1 = fa_cnt;
    peer_seen = 0;
    flush_req(1);
    wait_flush(1'b0);
    check("peer_done", 32'd1, 32'(peer_seen));
    check("ack_count", 32'(n1), 32'(fa_cnt));
    dual <= 1'b0;
    role <= 1'b0;
    tick(3);
  endtask
  task automatic t_dual_primary();
    @(posedge i_ref_clk);
    dual <= 1'b1;
    n1 = fa_cnt;
    flush_req(1);
    tick(30);
    check("ack_count", 32'(n1), 32'(fa_cnt));
    peer_in <= 1'b1;
    tick(1);
    peer_in <= 1'b0;
    wait_flush(1'b0);
    check("ack_count", 32'(n1 + 8'h01), 32'(fa_cnt));
    dual <= 1'b0;
  endtask
  task automatic t_tristate();
    @(posedge i_ref_clk);
    i_reset <= 1'b1;
    flush_n <= 1'b0;
    tick(16);
    i_reset <= 1'b0;
    tick(2);
    flush_n <= 1'b1;
    tick(1);
    #1;
    check("tristate", 32'd1, 32'(tristate));
  endtask

  initial begin
    tick(16);
    i_reset <= 1'b0;
    tick(3);
    #1;
    check("hit_n", 32'd1, 32'(hit_n));
    check("hit_mod_n", 32'd1, 32'(mod_n));
    check("tristate", 32'd0, 32'(tristate));
    t_snoops();
    t_mod_snoop();
    t_flush();
    t_halt_flush();
    t_dual_flush();
    t_dual_primary();
    t_tristate();
    end_sim();
  end
  initial begin
    tick(20000);
    errors++;
    end_sim();
  end
endmodule
